// ===== hw/dev_boot_gate.sv
// Purpose: Device end: bus slave, code loader, tuner relay, interrupt
// Assumes: Host keeps to 700 kbit/s; straps stable after reset
// Notes: All strap, tuner, EEPROM and host bus pins pass two flip-flops before use
`timescale 1ns/1ps
`include "boot_gate_consts.svh"
module dev_boot_gate import boot_gate_pkg::*; (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // Host link
  boot_gate_if.device bus,
  // Straps
  input wire logic [1:0] slave_addr_select_i,
  input wire logic eeprom_addr_select_i,
  input wire logic boot_source_select_i,
  // Tuner bus
  input wire logic tuner_bus_data_i,
  output logic tuner_bus_clock_oe_n_o,
  output logic tuner_bus_data_oe_n_o,
  // EEPROM bus
  output logic eeprom_bus_clock_o,
  input wire logic eeprom_bus_data_i,
  output logic eeprom_bus_data_oe_n_o,
  // Processor code port
  input wire logic [`CODE_AW-1:0] code_rd_addr_i,
  output logic [7:0] code_rd_data_o,
  output logic boot_done_o
);
  // ==========================================================
  // Input synchronisers
  logic [7:0] pin_raw, sync1_q, sync2_q, prev_q;
  assign pin_raw = {slave_addr_select_i, eeprom_addr_select_i, boot_source_select_i,
                    tuner_bus_data_i, eeprom_bus_data_i, bus.sda, bus.scl};
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      sync1_q <= 8'hff;
      sync2_q <= 8'hff;
      prev_q <= 8'hff;
    end else begin
      sync1_q <= pin_raw;
      sync2_q <= sync1_q;
      prev_q <= sync2_q;
    end
  end
  logic scl_s, sda_s, esda_s, tsda_s, boot_s, esel_s;
  logic [1:0] ssel_s;
  logic rise, fall, start, stop;
  assign scl_s = sync2_q[0];
  assign sda_s = sync2_q[1];
  assign esda_s = sync2_q[2];
  assign tsda_s = sync2_q[3];
  assign boot_s = sync2_q[4];
  assign esel_s = sync2_q[5];
  assign ssel_s = sync2_q[7:6];
  // Edges seen on the master bus
  assign rise = scl_s & ~prev_q[0];
  assign fall = ~scl_s & prev_q[0];
  assign start = scl_s & prev_q[0] & ~sda_s & prev_q[1];
  assign stop = scl_s & prev_q[0] & sda_s & ~prev_q[1];

  // ==========================================================
  // Register state
  logic [1:0] ctrl_q, ctrl_d;
  logic int_q, int_d, done_q, done_d;
  logic [`CODE_AW:0] cidx_q, cidx_d;
  logic [7:0] code_mem [0:`CODE_DEPTH-1];
  logic code_we;
  logic [7:0] code_wdata;
  logic slv_code_wr, eep_code_wr, clr_int;

  function automatic logic [7:0] reg_read(input logic [7:0] p, input logic [1:0] c,
                                          input logic irq, input logic dn,
                                          input logic [`CODE_AW:0] n);
    logic [7:0] v;
    v = 8'h00;
    case (p)
      `REG_CTRL: v = {6'h00, c};
      `REG_STATUS: v = {6'h00, dn, irq};
      `REG_CODE_CNT: v = {1'b0, n};
      default: v = 8'h00;
    endcase
    return v;
  endfunction : reg_read

  // ==========================================================
  // Master bus slave
  slave_state_t s_st_q, s_st_d;
  logic [3:0] cnt_q, cnt_d;
  logic [7:0] sh_q, sh_d, ptr_q, ptr_d, rd_byte;
  logic rw_q, rw_d, drv_q, drv_d, nack_q, nack_d;
  assign rd_byte = reg_read(ptr_q, ctrl_q, int_q, done_q, cidx_q);

  always_comb begin
    s_st_d = s_st_q;
    cnt_d = cnt_q;
    sh_d = sh_q;
    ptr_d = ptr_q;
    rw_d = rw_q;
    drv_d = drv_q;
    nack_d = nack_q;
    ctrl_d = ctrl_q;
    clr_int = 1'b0;
    slv_code_wr = 1'b0;
    if (start) begin
      s_st_d = S_ADDR;
      cnt_d = 4'h0;
      drv_d = 1'b0;
    end else if (stop) begin
      s_st_d = S_IDLE;
      drv_d = 1'b0;
    end else if (rise) begin
      case (s_st_q)
        S_ADDR, S_REG, S_WDATA: begin
          sh_d = {sh_q[6:0], sda_s};
          cnt_d = cnt_q + 4'h1;
        end
        S_RACK: nack_d = sda_s;
        default: ;
      endcase
    end else if (fall) begin
      case (s_st_q)
        S_ADDR: if (cnt_q == 4'h8) begin
          if (sh_q[7:1] == {`DEV_ADDR_HI, ssel_s}) begin
            drv_d = 1'b1;
            rw_d = sh_q[0];
            s_st_d = S_ACK_A;
          end else begin
            s_st_d = S_IDLE;
          end
        end
        S_REG: if (cnt_q == 4'h8) begin
          ptr_d = sh_q;
          drv_d = 1'b1;
          s_st_d = S_ACK_R;
        end
        S_WDATA: if (cnt_q == 4'h8) begin
          drv_d = 1'b1;
          s_st_d = S_ACK_W;
          case (ptr_q)
            `REG_CTRL: ctrl_d = sh_q[1:0];
            `REG_STATUS: clr_int = sh_q[`STAT_INT];
            `REG_CODE_IN: slv_code_wr = boot_s & ~done_q;
            default: ;
          endcase
          if (ptr_q != `REG_CODE_IN) begin
            ptr_d = ptr_q + 8'h01;
          end
        end
        S_ACK_A: begin
          if (rw_q) begin
            sh_d = {rd_byte[6:0], 1'b1};
            drv_d = ~rd_byte[7];
            cnt_d = 4'h1;
            s_st_d = S_RDATA;
          end else begin
            drv_d = 1'b0;
            cnt_d = 4'h0;
            s_st_d = S_REG;
          end
        end
        S_ACK_R, S_ACK_W: begin
          drv_d = 1'b0;
          cnt_d = 4'h0;
          s_st_d = S_WDATA;
        end
        S_RDATA: begin
          if (cnt_q == 4'h8) begin
            drv_d = 1'b0;
            ptr_d = ptr_q + 8'h01;
            s_st_d = S_RACK;
          end else begin
            drv_d = ~sh_q[7];
            sh_d = {sh_q[6:0], 1'b1};
            cnt_d = cnt_q + 4'h1;
          end
        end
        S_RACK: begin
          if (nack_q) begin
            s_st_d = S_IDLE;
          end else begin
            sh_d = {rd_byte[6:0], 1'b1};
            drv_d = ~rd_byte[7];
            cnt_d = 4'h1;
            s_st_d = S_RDATA;
          end
        end
        default: s_st_d = S_IDLE;
      endcase
    end
  end

  // ==========================================================
  // EEPROM code fetch master
  master_state_t m_st_q, m_st_d;
  logic [`QTR_W-1:0] div_q, div_d;
  logic [1:0] ph_q, ph_d;
  logic [2:0] ecnt_q, ecnt_d;
  logic [7:0] esh_q, esh_d;
  logic escl_q, escl_d, edrv_q, edrv_d, enack_q, enack_d, tick, last;
  assign tick = (div_q == `QTR_W'(`QTR_CYC - 1));
  assign last = (cidx_q == `CODE_DEPTH - 7'h01);

  always_comb begin
    m_st_d = m_st_q;
    div_d = tick ? '0 : div_q + `QTR_W'(1);
    ph_d = ph_q;
    ecnt_d = ecnt_q;
    esh_d = esh_q;
    escl_d = escl_q;
    edrv_d = edrv_q;
    enack_d = enack_q;
    eep_code_wr = 1'b0;
    if (tick && m_st_q != M_IDLE) begin
      ph_d = ph_q + 2'h1;
      if (ph_q == 2'h0 && m_st_q != M_START) escl_d = 1'b0;
      if (ph_q == 2'h3 && m_st_q != M_STOP) escl_d = 1'b0;
      if (ph_q == 2'h1) escl_d = 1'b1;
      case (m_st_q)
        M_START: begin
          if (ph_q == 2'h0) edrv_d = 1'b0;
          if (ph_q == 2'h2) edrv_d = 1'b1;
          if (ph_q == 2'h3) begin
            esh_d = {`EEP_ADDR_HI, esel_s, 1'b1};
            ecnt_d = 3'h0;
            m_st_d = M_TX;
          end
        end
        M_TX: begin
          if (ph_q == 2'h0) edrv_d = ~esh_q[7];
          if (ph_q == 2'h3) begin
            esh_d = {esh_q[6:0], 1'b0};
            ecnt_d = ecnt_q + 3'h1;
            if (ecnt_q == 3'h7) m_st_d = M_ACK;
          end
        end
        M_ACK, M_RX: begin
          if (ph_q == 2'h0) edrv_d = 1'b0;
          if (ph_q == 2'h2 && m_st_q == M_ACK) enack_d = esda_s;
          if (ph_q == 2'h2 && m_st_q == M_RX) esh_d = {esh_q[6:0], esda_s};
          if (ph_q == 2'h3) begin
            ecnt_d = m_st_q == M_ACK ? 3'h0 : ecnt_q + 3'h1;
            if (m_st_q == M_ACK) m_st_d = enack_q ? M_STOP : M_RX;
            else if (ecnt_q == 3'h7) m_st_d = M_MACK;
          end
        end
        M_MACK: begin
          if (ph_q == 2'h0) begin
            edrv_d = ~last;
            eep_code_wr = 1'b1;
          end
          if (ph_q == 2'h3) m_st_d = edrv_q ? M_RX : M_STOP;
        end
        M_STOP: begin
          if (ph_q == 2'h0) edrv_d = 1'b1;
          if (ph_q == 2'h2) edrv_d = 1'b0;
          if (ph_q == 2'h3) m_st_d = M_IDLE;
        end
        default: m_st_d = M_IDLE;
      endcase
    end else if (tick && !boot_s && !done_q) begin
      m_st_d = M_START;
      ph_d = 2'h0;
    end
  end

  // ==========================================================
  // Code store, boot status, interrupt, tuner relay
  logic fwd_q, fwd_d, rev_q, rev_d, gate;
  logic [2:0] hold_q, hold_d;
  assign code_we = slv_code_wr | eep_code_wr;
  assign code_wdata = slv_code_wr ? sh_q : esh_q;
  assign gate = ctrl_q[`CTRL_TUNER_EN];
  always_comb begin
    cidx_d = code_we ? cidx_q + 7'h01 : cidx_q;
    done_d = (cidx_d == `CODE_DEPTH);
    int_d = (done_d & ~done_q) | (int_q & ~clr_int);
    fwd_d = gate & ~sda_s & ~drv_q & ~rev_q & (fwd_q | hold_q == 3'h0);
    rev_d = gate & ~tsda_s & ~fwd_q & (rev_q | hold_q == 3'h0);
    if ((fwd_q & ~fwd_d) | (rev_q & ~rev_d)) hold_d = `RELAY_HOLD;
    else hold_d = hold_q == 3'h0 ? 3'h0 : hold_q - 3'h1;
  end

  always_ff @(posedge clock_i) begin
    if (code_we) code_mem[cidx_q[`CODE_AW-1:0]] <= code_wdata;
    code_rd_data_o <= code_mem[code_rd_addr_i];
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      s_st_q <= S_IDLE;
      cnt_q <= 4'h0;
      sh_q <= 8'h00;
      ptr_q <= 8'h00;
      rw_q <= 1'b0;
      drv_q <= 1'b0;
      nack_q <= 1'b1;
      ctrl_q <= `CTRL_RST;
      m_st_q <= M_IDLE;
      div_q <= '0;
      ph_q <= 2'h0;
      ecnt_q <= 3'h0;
      esh_q <= 8'h00;
      escl_q <= 1'b1;
      edrv_q <= 1'b0;
      enack_q <= 1'b1;
      cidx_q <= 7'h00;
      done_q <= 1'b0;
      int_q <= 1'b0;
      fwd_q <= 1'b0;
      rev_q <= 1'b0;
      hold_q <= 3'h0;
      bus.dev_sda_oe_n <= 1'b1;
      bus.dev_int_oe_n <= 1'b1;
      tuner_bus_clock_oe_n_o <= 1'b1;
      tuner_bus_data_oe_n_o <= 1'b1;
      eeprom_bus_clock_o <= 1'b1;
      eeprom_bus_data_oe_n_o <= 1'b1;
      boot_done_o <= 1'b0;
    end else begin
      s_st_q <= s_st_d;
      cnt_q <= cnt_d;
      sh_q <= sh_d;
      ptr_q <= ptr_d;
      rw_q <= rw_d;
      drv_q <= drv_d;
      nack_q <= nack_d;
      ctrl_q <= ctrl_d;
      m_st_q <= m_st_d;
      div_q <= div_d;
      ph_q <= ph_d;
      ecnt_q <= ecnt_d;
      esh_q <= esh_d;
      escl_q <= escl_d;
      edrv_q <= edrv_d;
      enack_q <= enack_d;
      cidx_q <= cidx_d;
      done_q <= done_d;
      int_q <= int_d;
      fwd_q <= fwd_d;
      rev_q <= rev_d;
      hold_q <= hold_d;
      bus.dev_sda_oe_n <= ~(drv_d | rev_d);
      bus.dev_int_oe_n <= ~(int_d & ctrl_d[`CTRL_INT_EN]);
      tuner_bus_clock_oe_n_o <= ~(gate & ~scl_s);
      tuner_bus_data_oe_n_o <= ~fwd_d;
      eeprom_bus_clock_o <= escl_d;
      eeprom_bus_data_oe_n_o <= ~edrv_d;
      boot_done_o <= done_d;
    end
  end
endmodule : dev_boot_gate

// ===== hw/boot_gate_consts.svh
// Purpose: Shared constants of the serial control block and its host
// Assumes: 20 MHz system clock
// Notes: Definitions only
`ifndef BOOT_GATE_CONSTS_SVH
`define BOOT_GATE_CONSTS_SVH
// ==========================================================
// Timing
`define CLK_KHZ 20000
`define BUS_MAX_KBPS 700
`define QTR_CYC ((`CLK_KHZ + `BUS_MAX_KBPS * 4 - 1) / (`BUS_MAX_KBPS * 4))
`define QTR_W 4
`define RELAY_HOLD 3'h4
// ==========================================================
// Addresses
`define DEV_ADDR_HI 5'h02
`define EEP_ADDR_HI 6'h28
// ==========================================================
// Register map
`define REG_CTRL 8'h00
`define REG_STATUS 8'h01
`define REG_CODE_IN 8'h02
`define REG_CODE_CNT 8'h03
`define CTRL_TUNER_EN 0
`define CTRL_INT_EN 1
`define CTRL_RST 2'h0
`define STAT_INT 0
`define STAT_BOOT_DONE 1
// ==========================================================
// Code store
`define CODE_DEPTH 7'h40
`define CODE_AW 6
`endif

// ===== hw/boot_gate_pkg.sv
// Purpose: Types shared by both ends
// Assumes: Nothing
// Notes: Constants live in boot_gate_consts.svh
package boot_gate_pkg;
  typedef enum logic [3:0] {
    S_IDLE, S_ADDR, S_ACK_A, S_REG, S_ACK_R, S_WDATA, S_ACK_W, S_RDATA, S_RACK
  } slave_state_t;
  typedef enum logic [2:0] {
    M_IDLE, M_START, M_TX, M_ACK, M_RX, M_MACK, M_STOP
  } master_state_t;
endpackage : boot_gate_pkg

// ===== hw/boot_gate_if.sv
// Purpose: Master serial bus and interrupt line between host and device
// Assumes: Pull-ups on every line
// Notes: Line levels resolved here from the enables
`timescale 1ns/1ps
interface boot_gate_if;
  logic host_scl_oe_n;
  logic host_sda_oe_n;
  logic dev_sda_oe_n;
  logic dev_int_oe_n;
  logic scl;
  logic sda;
  logic int_n;
  // Wired-AND with pull-up
  assign scl = host_scl_oe_n;
  assign sda = host_sda_oe_n & dev_sda_oe_n;
  assign int_n = dev_int_oe_n;
  modport host (output host_scl_oe_n, output host_sda_oe_n, input scl, input sda,
                input int_n);
  modport device (output dev_sda_oe_n, output dev_int_oe_n, input scl, input sda);
endinterface : boot_gate_if

// ===== hw/host_boot_gate.sv
// Purpose: Host end: single-register read and write master
// Assumes: Device slave address straps known to the host
// Notes: Bit rate held under 700 kbit/s
`timescale 1ns/1ps
`include "boot_gate_consts.svh"
module host_boot_gate import boot_gate_pkg::*; (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // Device link
  boot_gate_if.host bus,
  // Command port
  input wire logic req_i,
  input wire logic rd_i,
  input wire logic [7:0] reg_i,
  input wire logic [7:0] wdata_i,
  input wire logic [1:0] slave_addr_select_i,
  output logic busy_o,
  output logic done_o,
  output logic nack_o,
  output logic [7:0] rdata_o,
  output logic irq_o
);
  // ==========================================================
  // Synchronisers
  logic [1:0] s1_q, s2_q;
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      s1_q <= 2'h3;
      s2_q <= 2'h3;
    end else begin
      s1_q <= {bus.int_n, bus.sda};
      s2_q <= s1_q;
    end
  end
  // ==========================================================
  // Bus master
  master_state_t st_q, st_d;
  logic [`QTR_W-1:0] div_q, div_d;
  logic [1:0] ph_q, ph_d, idx_q, idx_d;
  logic [2:0] cnt_q, cnt_d;
  logic [7:0] sh_q, sh_d, reg_q, reg_d, wd_q, wd_d, rdata_d;
  logic rd_q, rd_d, scl_d, drv_q, drv_d, nack_d, done_d, tick;
  logic [6:0] addr;
  assign tick = (div_q == `QTR_W'(`QTR_CYC - 1));
  assign addr = {`DEV_ADDR_HI, slave_addr_select_i};

  always_comb begin
    st_d = st_q;
    div_d = tick ? '0 : div_q + `QTR_W'(1);
    ph_d = ph_q;
    idx_d = idx_q;
    cnt_d = cnt_q;
    sh_d = sh_q;
    reg_d = reg_q;
    wd_d = wd_q;
    rd_d = rd_q;
    scl_d = bus.host_scl_oe_n;
    drv_d = drv_q;
    nack_d = nack_o;
    rdata_d = rdata_o;
    done_d = 1'b0;
    if (st_q == M_IDLE) begin
      if (req_i) begin
        st_d = M_START;
        ph_d = 2'h0;
        idx_d = 2'h0;
        reg_d = reg_i;
        wd_d = wdata_i;
        rd_d = rd_i;
        nack_d = 1'b0;
        div_d = '0;
      end
    end else if (tick) begin
      ph_d = ph_q + 2'h1;
      if (ph_q == 2'h0 && st_q != M_START) scl_d = 1'b0;
      if (ph_q == 2'h3 && st_q != M_STOP) scl_d = 1'b0;
      if (ph_q == 2'h1) scl_d = 1'b1;
      case (st_q)
        M_START: begin
          if (ph_q == 2'h0) drv_d = 1'b0;
          if (ph_q == 2'h2) drv_d = 1'b1;
          if (ph_q == 2'h3) begin
            sh_d = {addr, idx_q != 2'h0};
            cnt_d = 3'h0;
            st_d = M_TX;
          end
        end
        M_TX: begin
          if (ph_q == 2'h0) drv_d = ~sh_q[7];
          if (ph_q == 2'h3) begin
            sh_d = {sh_q[6:0], 1'b0};
            cnt_d = cnt_q + 3'h1;
            if (cnt_q == 3'h7) st_d = M_ACK;
          end
        end
        M_ACK, M_RX: begin
          if (ph_q == 2'h0) drv_d = 1'b0;
          if (ph_q == 2'h2 && st_q == M_ACK) nack_d = s2_q[0];
          if (ph_q == 2'h2 && st_q == M_RX) sh_d = {sh_q[6:0], s2_q[0]};
          if (ph_q == 2'h3 && st_q == M_RX) begin
            cnt_d = cnt_q + 3'h1;
            if (cnt_q == 3'h7) st_d = M_MACK;
          end
          if (ph_q == 2'h3 && st_q == M_ACK) begin
            idx_d = idx_q + 2'h1;
            cnt_d = 3'h0;
            if (nack_o) st_d = M_STOP;
            else if (idx_q == 2'h0) begin
              sh_d = reg_q;
              st_d = M_TX;
            end else if (idx_q == 2'h1 && !rd_q) begin
              sh_d = wd_q;
              st_d = M_TX;
            end else if (idx_q == 2'h1) st_d = M_START;
            else if (rd_q && idx_q == 2'h2) st_d = M_RX;
            else st_d = M_STOP;
          end
        end
        M_MACK: begin
          if (ph_q == 2'h0) drv_d = 1'b0;
          if (ph_q == 2'h3) begin
            rdata_d = sh_q;
            st_d = M_STOP;
          end
        end
        M_STOP: begin
          if (ph_q == 2'h0) drv_d = 1'b1;
          if (ph_q == 2'h2) drv_d = 1'b0;
          if (ph_q == 2'h3) begin
            st_d = M_IDLE;
            done_d = 1'b1;
          end
        end
        default: st_d = M_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      st_q <= M_IDLE;
      div_q <= '0;
      ph_q <= 2'h0;
      idx_q <= 2'h0;
      cnt_q <= 3'h0;
      sh_q <= 8'h00;
      reg_q <= 8'h00;
      wd_q <= 8'h00;
      rd_q <= 1'b0;
      drv_q <= 1'b0;
      bus.host_scl_oe_n <= 1'b1;
      bus.host_sda_oe_n <= 1'b1;
      busy_o <= 1'b0;
      done_o <= 1'b0;
      nack_o <= 1'b0;
      rdata_o <= 8'h00;
      irq_o <= 1'b0;
    end else begin
      st_q <= st_d;
      div_q <= div_d;
      ph_q <= ph_d;
      idx_q <= idx_d;
      cnt_q <= cnt_d;
      sh_q <= sh_d;
      reg_q <= reg_d;
      wd_q <= wd_d;
      rd_q <= rd_d;
      drv_q <= drv_d;
      bus.host_scl_oe_n <= scl_d;
      bus.host_sda_oe_n <= ~drv_d;
      busy_o <= (st_d != M_IDLE);
      done_o <= done_d;
      nack_o <= nack_d;
      rdata_o <= rdata_d;
      irq_o <= ~s2_q[1];
    end
  end
endmodule : host_boot_gate

// ===== testbench/boot_gate_sva.sv
// Purpose: Wire checks on the host link
// Assumes: One clock domain
// Notes: Instantiated beside the link
`timescale 1ns/1ps
module boot_gate_sva (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // Link signals
  input wire logic host_scl_oe_n,
  input wire logic host_sda_oe_n,
  input wire logic dev_sda_oe_n,
  input wire logic dev_int_oe_n,
  input wire logic scl,
  input wire logic sda,
  input wire logic int_n
);
  // ==========================================
  // Cycles since last clock rise
  logic [5:0] gap_q;
  logic [5:0] gap_d;
  logic scl_q;
  always_comb begin
    gap_d = (scl && !scl_q) ? 6'h00 : ((gap_q == 6'h3f) ? gap_q : gap_q + 6'h01);
  end
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      gap_q <= 6'h3f;
      scl_q <= 1'b1;
    end else begin
      gap_q <= gap_d;
      scl_q <= scl;
    end
  end
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  // ==========================================
  // Assertions
  chk_reset_idle: assert property (disable iff (1'b0)
    rst_i |-> host_scl_oe_n && host_sda_oe_n && dev_sda_oe_n && dev_int_oe_n)
    else $error("link driven during reset");
  chk_bit_rate: assert property (scl && !scl_q |-> gap_q >= 6'h1c)
    else $error("clock period too short");
  chk_scl_high_min: assert property ($rose(scl) |=> scl[*8])
    else $error("clock high phase too short");
  chk_scl_low_min: assert property ($fell(scl) |=> !scl[*8])
    else $error("clock low phase too short");
  chk_data_hold: assert property (
    $changed(dev_sda_oe_n) |-> !scl && !$past(scl) && !$past(scl, 2))
    else $error("device data moved near clock high");
  chk_ack_holds: assert property ($fell(dev_sda_oe_n) |=> !dev_sda_oe_n[*8])
    else $error("device low too short");
  chk_ack_before_rise: assert property ($fell(dev_sda_oe_n) |-> ##[1:16] $rose(scl))
    else $error("device low not set up before clock");
  chk_host_setup: assert property ($changed(host_sda_oe_n) |-> $stable(scl))
    else $error("host data moved with clock");
  chk_int_quiet: assert property ($fell(rst_i) |-> int_n[*8])
    else $error("interrupt low after reset");
  cover property ($fell(dev_sda_oe_n));
  cover property ($fell(int_n));
  cover property ($rose(int_n));
  cover property (scl && $fell(sda));
endmodule : boot_gate_sva

// ===== testbench/tb_host_i2c_boot_and_tuner_gate.sv
// Purpose: Both ends joined, host and EEPROM boot exercised
// Assumes: Tuner line released; EEPROM answered by bench
// Notes: EEPROM byte n holds value n
`timescale 1ns/1ps
`include "boot_gate_consts.svh"
module tb_host_i2c_boot_and_tuner_gate;
  logic clock_i = 1'b1;
  logic rst_i = 1'b0;
  logic req = 1'b0;
  logic rd_in = 1'b0;
  logic boot_src = 1'b1;
  logic eep_sel = 1'b0;
  logic [7:0] reg_in = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic [1:0] host_sel = 2'h2;
  logic [1:0] dev_sel = 2'h2;
  logic [5:0] code_addr = 6'h00;
  logic ee_drv = 1'b1;
  logic ee_addr_ph = 1'b1;
  logic [3:0] ebit = 4'h0;
  logic [7:0] ebyte = 8'h00;
  logic [7:0] eshift = 8'h00;
  logic [7:0] eaddr = 8'h00;
  wire logic busy, done, nack, irq, tclk_oe_n, tdat_oe_n, eclk, edat_oe_n, boot_done;
  wire logic [7:0] rdata;
  wire logic [7:0] code_data;
  wire logic ee_line = edat_oe_n & ee_drv;
  int n_mismatch = 0;
  int check_count = 0;
  int cyc = 0;
  int tclk_n = 0;
  int tdat_n = 0;
  int snap_c;
  int snap_d;
  int n;
  always #25 clock_i = ~clock_i;
  boot_gate_if link ();
  host_boot_gate host_boot_gate_inst (.clock_i(clock_i), .rst_i(rst_i), .bus(link),
    .req_i(req), .rd_i(rd_in), .reg_i(reg_in), .wdata_i(wdata),
    .slave_addr_select_i(host_sel), .busy_o(busy), .done_o(done), .nack_o(nack),
    .rdata_o(rdata), .irq_o(irq));
  dev_boot_gate dev_boot_gate_inst (.clock_i(clock_i), .rst_i(rst_i), .bus(link),
    .slave_addr_select_i(dev_sel), .eeprom_addr_select_i(eep_sel),
    .boot_source_select_i(boot_src), .tuner_bus_data_i(tdat_oe_n),
    .tuner_bus_clock_oe_n_o(tclk_oe_n), .tuner_bus_data_oe_n_o(tdat_oe_n),
    .eeprom_bus_clock_o(eclk), .eeprom_bus_data_i(ee_line),
    .eeprom_bus_data_oe_n_o(edat_oe_n), .code_rd_addr_i(code_addr),
    .code_rd_data_o(code_data), .boot_done_o(boot_done));
  boot_gate_sva boot_gate_sva_inst (.clock_i(clock_i), .rst_i(rst_i),
    .host_scl_oe_n(link.host_scl_oe_n), .host_sda_oe_n(link.host_sda_oe_n),
    .dev_sda_oe_n(link.dev_sda_oe_n), .dev_int_oe_n(link.dev_int_oe_n),
    .scl(link.scl), .sda(link.sda), .int_n(link.int_n));
  // ==========================================
  // Tuner activity, EEPROM responder, timeout
  always @(posedge clock_i) begin
    cyc <= cyc + 1;
    if ($fell(tclk_oe_n)) tclk_n <= tclk_n + 1;
    if ($fell(tdat_oe_n)) tdat_n <= tdat_n + 1;
    if (rst_i || (eclk && $fell(ee_line))) begin
      ebit <= 4'h0;
      ee_addr_ph <= 1'b1;
      ee_drv <= 1'b1;
      if (rst_i) ebyte <= 8'h00;
    end else if ($rose(eclk)) begin
      eshift <= {eshift[6:0], ee_line};
      if (ee_addr_ph && ebit == 4'h7) eaddr <= {eshift[6:0], ee_line};
      ebit <= (ebit == 4'h8) ? 4'h0 : ebit + 4'h1;
      if (ebit == 4'h8) ee_addr_ph <= !ee_addr_ph && ee_line;
      if (ebit == 4'h8 && !ee_addr_ph) ebyte <= ebyte + 8'h01;
    end else if ($fell(eclk)) begin
      ee_drv <= ee_addr_ph ? (ebit != 4'h8) : ((ebit == 4'h8) | ebyte[3'h7 - ebit[2:0]]);
    end
    if (cyc == 60000) begin
      n_mismatch++;
      final_report();
    end
  end
  task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk8
  task automatic chk1(input string what, input logic exp, input logic got);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %b seen %b", what, exp, got);
    end
  endtask : chk1
  task automatic host_cmd(input logic rd, input logic [7:0] r, input logic [7:0] wd);
    @(negedge clock_i);
    req = 1'b1;
    rd_in = rd;
    reg_in = r;
    wdata = wd;
    @(negedge clock_i);
    req = 1'b0;
    chk1("host busy", 1'b1, busy);
    n = 0;
    while (done !== 1'b1 && n < 5000) begin
      @(negedge clock_i);
      n++;
    end
    chk1("host done", 1'b1, done);
    chk1("host idle", 1'b0, busy);
  endtask : host_cmd
  task automatic code_chk(input logic [5:0] a, input logic [7:0] exp);
    @(negedge clock_i);
    code_addr = a;
    @(negedge clock_i);
    chk8("code byte", exp, code_data);
  endtask : code_chk
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : final_report
  // ==========================================
  // Tests
  initial begin
    @(negedge clock_i);
    rst_i = 1'b1;
    repeat (8) @(negedge clock_i);
    rst_i = 1'b0;
    chk8("idle enables", 8'h0f, {4'h0, tclk_oe_n, tdat_oe_n, edat_oe_n, eclk});
    chk1("boot done", 1'b0, boot_done);
    $display("test reset done");
    host_cmd(1'b0, `REG_CTRL, 8'h02);
    chk1("nack", 1'b0, nack);
    host_cmd(1'b1, `REG_CTRL, 8'h00);
    chk8("ctrl", 8'h02, rdata);
    chk1("tuner isolated", 1'b1, tclk_n == 0 && tdat_n == 0);
    host_cmd(1'b0, `REG_CODE_IN, 8'h3c);
    host_cmd(1'b0, `REG_CODE_IN, 8'h5a);
    host_cmd(1'b1, `REG_CODE_CNT, 8'h00);
    chk8("code count", 8'h02, rdata);
    host_cmd(1'b1, `REG_CODE_IN, 8'h00);
    chk8("code in read", 8'h00, rdata);
    code_chk(6'h00, 8'h3c);
    code_chk(6'h01, 8'h5a);
    chk1("eeprom clock idle", 1'b1, eclk);
    host_cmd(1'b1, 8'h07, 8'h00);
    chk8("unmapped", 8'h00, rdata);
    host_sel = 2'h1;
    host_cmd(1'b0, `REG_CTRL, 8'h01);
    chk1("nack", 1'b1, nack);
    dev_sel = 2'h1;
    host_cmd(1'b0, `REG_CTRL, 8'h01);
    chk1("nack", 1'b0, nack);
    snap_c = tclk_n;
    snap_d = tdat_n;
    host_cmd(1'b1, `REG_CTRL, 8'h00);
    chk8("ctrl", 8'h01, rdata);
    chk1("tuner relay", 1'b1, tclk_n > snap_c && tdat_n > snap_d);
    $display("test host boot done");
    boot_src = 1'b0;
    eep_sel = 1'b1;
    rst_i = 1'b1;
    repeat (8) @(negedge clock_i);
    rst_i = 1'b0;
    n = 0;
    while (boot_done !== 1'b1 && n < 30000) begin
      @(negedge clock_i);
      n++;
    end
    chk1("boot done", 1'b1, boot_done);
    chk8("eeprom address", {`EEP_ADDR_HI, 1'b1, 1'b1}, eaddr);
    host_cmd(1'b0, `REG_CODE_IN, 8'ha5);
    host_cmd(1'b1, `REG_CODE_CNT, 8'h00);
    chk8("code count", 8'h40, rdata);
    for (int k = 0; k < 64; k += 21) begin
      code_chk(6'(k), 8'(k));
    end
    host_cmd(1'b1, `REG_STATUS, 8'h00);
    chk8("status", 8'h03, rdata);
    chk1("irq", 1'b0, irq);
    host_cmd(1'b0, `REG_CTRL, 8'h02);
    chk1("irq", 1'b1, irq);
    host_cmd(1'b0, `REG_STATUS, 8'h01);
    chk1("irq", 1'b0, irq);
    $display("test eeprom boot done");
    final_report();
  end
endmodule : tb_host_i2c_boot_and_tuner_gate
